//--- eps_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "eps_map.svh"

module eps_host
	import eps_pkg::*;
#(
	parameter int HALF_CYC   = `EPS_SCL_HALF_CYC,
	parameter int CSSU_CYC   = `EPS_CSSU_CYC,
	parameter int CSHLD_CYC  = `EPS_CSHLD_CYC,
	parameter int CSHIGH_CYC = `EPS_CSHIGH_CYC
)
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	eps_link_if.host        link,
	input  wire logic       start,
	input  wire logic       startIsData,
	input  wire eps_byte_t  txByte,
	input  wire logic [3:0] rdCount,
	input  wire logic       threeWire,
	input  wire logic       resetReq,
	input  wire logic       refreshDone,
	input  wire logic       refreshIsFull,
	output logic            ready,
	output logic            done,
	output logic            rdValid,
	output eps_byte_t       rdByte,
	output logic            fullRefreshDue
);

	eps_host_state_t state_reg;
	logic [7:0]      divCnt_reg;
	logic [6:0]      bitCnt_reg;
	logic [3:0]      txLen_reg;
	logic [6:0]      totLen_reg;
	logic [9:0]      txVec_reg;
	eps_byte_t       rxShift_reg;
	logic            isRead_reg;
	logic            sclk_reg;
	logic            csN_reg;
	logic            dc_reg;
	logic            sdaO_reg;
	logic            sdaOe_reg;
	logic            strap_reg;
	logic            resN_reg;
	logic            busyS1_reg;
	logic            busyS2_reg;
	logic            sdaS1_reg;
	logic            sdaS2_reg;
	logic [2:0]      partCnt_reg;

	wire       isReadReq = (rdCount != 4'h0);
	wire [6:0] lowIdx    = (state_reg == EPS_HIGH) ? bitCnt_reg + 7'h01
	                                               : bitCnt_reg;
	wire       txPhase   = (lowIdx < {3'h0, txLen_reg});
	wire       rxPhase   = (bitCnt_reg >= {3'h0, txLen_reg});
	wire       halfDone  = (divCnt_reg == 8'(HALF_CYC - 1));
	wire       lastBit   = (bitCnt_reg + 7'h01 == totLen_reg);
	wire [6:0] rxIdx     = bitCnt_reg - {3'h0, txLen_reg};
	wire       canStart  = start && !busyS2_reg;
	wire [3:0] len3      = 4'(`EPS_WORD3_BITS);
	wire [3:0] len4      = 4'(`EPS_WORD4_BITS);
	wire [3:0] lenRd3    = 4'(`EPS_WORD3_BITS + `EPS_RD3_LEAD_BITS);

	assign link.sclk          = sclk_reg;
	assign link.csN           = csN_reg;
	assign link.dc            = dc_reg;
	assign link.sdaHost       = sdaO_reg;
	assign link.sdaHostOe     = sdaOe_reg;
	assign link.busWidthStrap = strap_reg;
	assign link.resetInN      = resN_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busyS1_reg <= 1'b0;
			busyS2_reg <= 1'b0;
			sdaS1_reg  <= 1'b1;
			sdaS2_reg  <= 1'b1;
			strap_reg  <= 1'b0;
			resN_reg   <= 1'b0;
		end
		else
		begin
			busyS1_reg <= link.busy;
			busyS2_reg <= busyS1_reg;
			sdaS1_reg  <= link.sda;
			sdaS2_reg  <= sdaS1_reg;
			strap_reg  <= threeWire;
			resN_reg   <= !resetReq;
		end
	end

	// Afterimage guard: count fast/partial refreshes since the last full
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			partCnt_reg    <= 3'h0;
			fullRefreshDue <= 1'b0;
		end
		else if (refreshDone)
		begin
			if (refreshIsFull)
				partCnt_reg <= 3'h0;
			else if (partCnt_reg != 3'(`EPS_PARTIAL_LIMIT))
				partCnt_reg <= partCnt_reg + 3'h1;
			fullRefreshDue <= !refreshIsFull &&
				(partCnt_reg + 3'h1 >= 3'(`EPS_PARTIAL_LIMIT));
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg   <= EPS_IDLE;
			divCnt_reg  <= 8'h00;
			bitCnt_reg  <= 7'h00;
			txLen_reg   <= 4'h0;
			totLen_reg  <= 7'h00;
			txVec_reg   <= 10'h000;
			rxShift_reg <= 8'h00;
			isRead_reg  <= 1'b0;
			sclk_reg    <= 1'b0;
			csN_reg     <= 1'b1;
			dc_reg      <= 1'b0;
			sdaO_reg    <= 1'b0;
			sdaOe_reg   <= 1'b0;
			ready       <= 1'b0;
			done        <= 1'b0;
			rdValid     <= 1'b0;
			rdByte      <= 8'h00;
		end
		else
		begin
			done       <= 1'b0;
			rdValid    <= 1'b0;
			divCnt_reg <= divCnt_reg + 8'h01;
			case (state_reg)
				EPS_IDLE:
				begin
					divCnt_reg <= 8'h00;
					bitCnt_reg <= 7'h00;
					ready      <= !busyS2_reg && !canStart;
					if (canStart)
					begin
						state_reg  <= EPS_LEAD;
						csN_reg    <= 1'b0;
						isRead_reg <= isReadReq;
						// 3-wire keeps the pin low; a read opens as a command
						dc_reg     <= !strap_reg && !isReadReq
						              && startIsData;
						if (strap_reg)
						begin
							txVec_reg <= {!isReadReq && startIsData, txByte,
							              1'b1};
							txLen_reg <= isReadReq ? lenRd3 : len3;
						end
						else
						begin
							txVec_reg <= {txByte, 2'h0};
							txLen_reg <= len4;
						end
						totLen_reg <= {3'h0, strap_reg ? (isReadReq ? lenRd3 : len3)
						                               : len4}
						              + {rdCount, 3'h0};
					end
				end
				EPS_LEAD:
				begin
					if (divCnt_reg == 8'(CSSU_CYC - 1))
					begin
						state_reg  <= EPS_LOW;
						divCnt_reg <= 8'h00;
						sdaO_reg   <= txVec_reg[9];
						txVec_reg  <= {txVec_reg[8:0], 1'b0};
						sdaOe_reg  <= 1'b1;
					end
				end
				EPS_LOW:
				begin
					if (halfDone)
					begin
						state_reg  <= EPS_HIGH;
						divCnt_reg <= 8'h00;
						sclk_reg   <= 1'b1;
						if (rxPhase)
						begin
							rxShift_reg <= {rxShift_reg[6:0], sdaS2_reg};
							if (rxIdx[2:0] == 3'h7)
							begin
								rdValid <= 1'b1;
								rdByte  <= {rxShift_reg[6:0], sdaS2_reg};
							end
						end
					end
				end
				EPS_HIGH:
				begin
					if (halfDone)
					begin
						divCnt_reg <= 8'h00;
						sclk_reg   <= 1'b0;
						bitCnt_reg <= bitCnt_reg + 7'h01;
						if (lastBit)
							state_reg <= EPS_TRAIL;
						else
						begin
							state_reg <= EPS_LOW;
							sdaOe_reg <= txPhase;
							if (txPhase)
							begin
								sdaO_reg  <= txVec_reg[9];
								txVec_reg <= {txVec_reg[8:0], 1'b0};
							end
							else if (isRead_reg && !strap_reg)
								dc_reg <= 1'b1;
						end
					end
				end
				EPS_TRAIL:
				begin
					if (divCnt_reg == 8'(CSHLD_CYC - 1))
					begin
						state_reg  <= EPS_GAP;
						divCnt_reg <= 8'h00;
						csN_reg    <= 1'b1;
						sdaOe_reg  <= 1'b0;
						dc_reg     <= 1'b0;
					end
				end
				EPS_GAP:
				begin
					if (divCnt_reg == 8'(CSHIGH_CYC - 1))
					begin
						state_reg <= EPS_IDLE;
						done      <= 1'b1;
					end
				end
				default:
					state_reg <= EPS_IDLE;
			endcase
		end
	end

endmodule // eps_host

`default_nettype wire

//--- eps_map.svh
`ifndef EPS_MAP_SVH
`define EPS_MAP_SVH

// System clock period
`define EPS_CLK_NS        50
// Serial clock phase minimum (read mode governs both modes)
`define EPS_SCL_HALF_NS   180
`define EPS_SCL_HALF_CYC  ((`EPS_SCL_HALF_NS + `EPS_CLK_NS - 1) / `EPS_CLK_NS)
// Chip select set-up before first rising edge
`define EPS_CSSU_NS       100
`define EPS_CSSU_CYC      ((`EPS_CSSU_NS + `EPS_CLK_NS - 1) / `EPS_CLK_NS)
// Chip select hold after last falling edge
`define EPS_CSHLD_NS      65
`define EPS_CSHLD_CYC     ((`EPS_CSHLD_NS + `EPS_CLK_NS - 1) / `EPS_CLK_NS)
// Chip select high time between two transfers
`define EPS_CSHIGH_NS     250
`define EPS_CSHIGH_CYC    ((`EPS_CSHIGH_NS + `EPS_CLK_NS - 1) / `EPS_CLK_NS)

// Serial word lengths
`define EPS_WORD4_BITS    8
`define EPS_WORD3_BITS    9
// Extra data/command bit that opens a 3-wire read
`define EPS_RD3_LEAD_BITS 1
// Fast or partial refreshes allowed before a full refresh
`define EPS_PARTIAL_LIMIT 5

`endif

//--- eps_pkg.sv
`default_nettype none

package eps_pkg;

	typedef logic [7:0] eps_byte_t;

	typedef enum logic [2:0] {
		EPS_IDLE,
		EPS_LEAD,
		EPS_LOW,
		EPS_HIGH,
		EPS_TRAIL,
		EPS_GAP
	} eps_host_state_t;

endpackage

`default_nettype wire

//--- eps_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface eps_link_if;
	logic sclk;
	logic csN;
	logic dc;
	logic sdaHost;
	logic sdaHostOe;
	logic sdaDev;
	logic sdaDevOe;
	logic sda;
	logic resetInN;
	logic busWidthStrap;
	logic busy;

	// Device read data wins; an undriven line idles high (pull-up)
	assign sda = sdaDevOe ? sdaDev : (sdaHostOe ? sdaHost : 1'b1);

	modport host (
		output sclk, csN, dc, sdaHost, sdaHostOe, resetInN, busWidthStrap,
		input  sda, busy
	);

	modport dev (
		input  sclk, csN, dc, sda, resetInN, busWidthStrap,
		output sdaDev, sdaDevOe, busy
	);
endinterface

`default_nettype wire

//--- eps_dev.sv
// What this block and its host do
// - Serial traffic accepted only while select low
// - 4-wire: DC pin high data, low command
// - Busy high during waveform or sensor traffic
// - Host sends nothing while busy is high
// - Strap low 8-bit 4-wire, high 9-bit 3-wire
// - 3-wire: DC pin held low, bit in stream
// - 4-wire: sample data on rising edge, MSB first
// - Host holds DC level over each byte
// - Completed byte routed by data/command flag
// - 4-wire read: host raises DC after last command falling edge
// - Read bytes shifted out on falling edges
// - Read ends by select high; output released
// - 3-wire word: DC bit then bits 7..0
// - 3-wire: leading 1 data, 0 command
// - 3-wire read: command, then one 1 bit
// - Reset input low holds device in reset
// - Full refresh after five partial refreshes
`timescale 1ns/1ps
`default_nettype none
`include "eps_map.svh"

module eps_dev
	import eps_pkg::*;
#(
	// Commands that answer with read data; one bit per opcode
	parameter logic [255:0] READ_CMDS = 256'h0
)
(
	input  wire logic      clk,
	input  wire logic      rst_n,
	eps_link_if.dev        link,
	input  wire logic      waveformActive,
	input  wire logic      sensorActive,
	input  wire eps_byte_t rdData,
	output logic           rxValid,
	output logic           rxIsData,
	output eps_byte_t      rxByte,
	output logic           rdTaken,
	output logic           busy,
	output logic           threeWireMode
);

	// Link-domain state (serial clock)
	logic [3:0] bitCnt_reg;
	logic [7:0] shiftIn_reg;
	logic       rdArm_reg;
	logic       rdWait_reg;
	eps_byte_t  wordByte_reg;
	logic       wordIsData_reg;
	logic       wordTgl_reg;
	eps_byte_t  outShift_reg;
	logic [2:0] outCnt_reg;
	logic       sdaOut_reg;
	logic       sdaOe_reg;
	logic       takeTgl_reg;

	// System-domain state
	logic       resS1_reg;
	logic       resS2_reg;
	logic       strapS1_reg;
	logic       strapS2_reg;
	logic       wordS1_reg;
	logic       wordS2_reg;
	logic       wordS3_reg;
	logic       takeS1_reg;
	logic       takeS2_reg;
	logic       takeS3_reg;

	// Select high or reset pin low wipes the link logic except the hand-off
	// registers and toggles. The serial clock stops between frames, so only
	// an asynchronous clear can realign the next frame.
	wire linkClr = link.csN || !link.resetInN;

	// Strap is a static board level; the synchronised copy is treated
	// as quasi-static by the link logic.
	wire       mode3 = threeWireMode;
	wire [3:0] lastIdx = mode3 ? 4'(`EPS_WORD3_BITS - 1)
	                           : 4'(`EPS_WORD4_BITS - 1);
	wire       wordDone = (bitCnt_reg == lastIdx);
	wire [7:0] newByte  = {shiftIn_reg[6:0], link.sda};
	// 3-wire flag is the first bit shifted; 4-wire uses the pin
	wire       newIsData = mode3 ? shiftIn_reg[7] : link.dc;
	wire       newIsRead = !newIsData && READ_CMDS[newByte];
	wire       loadOut   = rdArm_reg && (!sdaOe_reg || outCnt_reg == 3'h7);

	assign link.sdaDev   = sdaOut_reg;
	assign link.sdaDevOe = sdaOe_reg;
	assign link.busy     = busy;

	always_ff @(posedge link.sclk or posedge linkClr)
	begin
		if (linkClr)
		begin
			bitCnt_reg  <= 4'h0;
			shiftIn_reg <= 8'h00;
			rdArm_reg   <= 1'b0;
			rdWait_reg  <= 1'b0;
		end
		else if (rdWait_reg)
		begin
			// A 0 here is not a read opener and is dropped
			rdWait_reg <= 1'b0;
			rdArm_reg  <= link.sda;
		end
		else if (!rdArm_reg)
		begin
			shiftIn_reg <= newByte;
			bitCnt_reg  <= wordDone ? 4'h0 : bitCnt_reg + 4'h1;
			if (wordDone && newIsRead)
			begin
				rdArm_reg  <= !mode3;
				rdWait_reg <= mode3;
			end
		end
	end

	// Word hand-off registers survive select so the toggle stays honest
	always_ff @(posedge link.sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wordByte_reg   <= 8'h00;
			wordIsData_reg <= 1'b0;
			wordTgl_reg    <= 1'b0;
		end
		else if (!linkClr && !rdArm_reg && !rdWait_reg && wordDone)
		begin
			wordByte_reg   <= newByte;
			wordIsData_reg <= newIsData;
			wordTgl_reg    <= !wordTgl_reg;
		end
	end

	// Read data leaves on falling edges; rdData must already hold the
	// next byte when a load happens, since the core cannot answer
	// within half a serial clock.
	always_ff @(negedge link.sclk or posedge linkClr)
	begin
		if (linkClr)
		begin
			outShift_reg <= 8'h00;
			outCnt_reg   <= 3'h0;
			sdaOut_reg   <= 1'b0;
			sdaOe_reg    <= 1'b0;
		end
		else if (loadOut)
		begin
			outShift_reg <= {rdData[6:0], 1'b0};
			sdaOut_reg   <= rdData[7];
			outCnt_reg   <= 3'h0;
			sdaOe_reg    <= 1'b1;
		end
		else if (rdArm_reg)
		begin
			sdaOut_reg   <= outShift_reg[7];
			outShift_reg <= {outShift_reg[6:0], 1'b0};
			outCnt_reg   <= outCnt_reg + 3'h1;
		end
	end

	always_ff @(negedge link.sclk or negedge rst_n)
	begin
		if (!rst_n)
			takeTgl_reg <= 1'b0;
		else if (!linkClr && loadOut)
			takeTgl_reg <= !takeTgl_reg;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			resS1_reg   <= 1'b0;
			resS2_reg   <= 1'b0;
			strapS1_reg <= 1'b0;
			strapS2_reg <= 1'b0;
			wordS1_reg  <= 1'b0;
			wordS2_reg  <= 1'b0;
			wordS3_reg  <= 1'b0;
			takeS1_reg  <= 1'b0;
			takeS2_reg  <= 1'b0;
			takeS3_reg  <= 1'b0;
		end
		else
		begin
			resS1_reg   <= link.resetInN;
			resS2_reg   <= resS1_reg;
			strapS1_reg <= link.busWidthStrap;
			strapS2_reg <= strapS1_reg;
			wordS1_reg  <= wordTgl_reg;
			wordS2_reg  <= wordS1_reg;
			wordS3_reg  <= wordS2_reg;
			takeS1_reg  <= takeTgl_reg;
			takeS2_reg  <= takeS1_reg;
			takeS3_reg  <= takeS2_reg;
		end
	end

	wire wordEvt = wordS2_reg ^ wordS3_reg;
	wire takeEvt = takeS2_reg ^ takeS3_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxValid       <= 1'b0;
			rxIsData      <= 1'b0;
			rxByte        <= 8'h00;
			rdTaken       <= 1'b0;
			busy          <= 1'b0;
			threeWireMode <= 1'b0;
		end
		else if (!resS2_reg)
		begin
			// Held in reset: no events, busy low, strap re-read
			rxValid       <= 1'b0;
			rdTaken       <= 1'b0;
			busy          <= 1'b0;
			threeWireMode <= strapS2_reg;
		end
		else
		begin
			rxValid <= wordEvt;
			rdTaken <= takeEvt;
			if (wordEvt)
			begin
				rxByte   <= wordByte_reg;
				rxIsData <= wordIsData_reg;
			end
			busy <= waveformActive || sensorActive;
		end
	end

endmodule // eps_dev

`default_nettype wire

//--- eps_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module eps_link_asserts
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic csN,
	input wire logic dc,
	input wire logic sdaHost,
	input wire logic sdaHostOe,
	input wire logic sdaDev,
	input wire logic sdaDevOe,
	input wire logic resetInN,
	input wire logic busWidthStrap,
	input wire logic busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_deselect_release: assert property (csN [*4] |-> !sdaDevOe)
		else $error("device drives data while deselected");
	chk_cs_setup: assert property ($fell(csN) |-> !sclk [*3])
		else $error("clock rose too soon after select");
	chk_cs_hold: assert property ($rose(csN) |-> !$past(sclk, 2))
		else $error("select released too soon after clock");
	chk_host_data_steady: assert property (
		sdaHostOe && sclk |-> $stable(sdaHost))
		else $error("host data moved while clock high");
	chk_dev_data_steady: assert property (
		sdaDevOe && sclk && $past(sclk) |-> $stable(sdaDev))
		else $error("read data moved while clock high");
	chk_read_after_dc: assert property (
		$rose(sdaDevOe) && !busWidthStrap |-> dc)
		else $error("read data before data/command raised");
	chk_dc_steady: assert property (!csN && sclk |-> $stable(dc))
		else $error("data/command moved inside a byte");
	chk_three_wire_dc: assert property (busWidthStrap && !csN |-> !dc)
		else $error("data/command pin not low in 3-wire mode");
	chk_no_send_busy: assert property (busy [*6] |=> !$fell(csN))
		else $error("transfer opened while busy");
	chk_quiet_in_reset: assert property (
		!resetInN [*4] |-> !busy && !sdaDevOe)
		else $error("device active while held in reset");

	cover property ($rose(sdaDevOe));
	cover property (busWidthStrap && $fell(csN));
	cover property ($rose(busy));
endmodule // eps_link_asserts

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
	import eps_pkg::*;
;
	localparam eps_byte_t RD_CMD = 8'h2F;
	logic clk, rst_n, start, startIsData, threeWire, resetReq;
	logic refreshDone, refreshIsFull, waveformActive, sensorActive;
	logic ready, done, rdValid, fullRefreshDue, rxValid, rxIsData;
	logic rdTaken, busy, threeWireMode;
	eps_byte_t txByte, rdByte, rxByte;
	eps_byte_t rdData = 8'h5A;
	logic [3:0] rdCount;
	logic [31:0] seed = 32'h9B174ACA;
	int badCount, nTests, i, j;
	logic [8:0] rxQ[$];
	eps_byte_t rdQ[$];

	eps_link_if link();
	eps_host eps_host_inst (.clk(clk), .rst_n(rst_n), .link(link.host),
		.start(start), .startIsData(startIsData), .txByte(txByte),
		.rdCount(rdCount), .threeWire(threeWire), .resetReq(resetReq),
		.refreshDone(refreshDone), .refreshIsFull(refreshIsFull),
		.ready(ready), .done(done), .rdValid(rdValid), .rdByte(rdByte),
		.fullRefreshDue(fullRefreshDue));
	eps_dev #(.READ_CMDS(256'h1 << RD_CMD)) eps_dev_inst (.clk(clk),
		.rst_n(rst_n), .link(link.dev), .waveformActive(waveformActive),
		.sensorActive(sensorActive), .rdData(rdData), .rxValid(rxValid),
		.rxIsData(rxIsData), .rxByte(rxByte), .rdTaken(rdTaken),
		.busy(busy), .threeWireMode(threeWireMode));
	eps_link_asserts eps_link_asserts_inst (.clk(clk), .rst_n(rst_n),
		.sclk(link.sclk), .csN(link.csN), .dc(link.dc),
		.sdaHost(link.sdaHost), .sdaHostOe(link.sdaHostOe),
		.sdaDev(link.sdaDev), .sdaDevOe(link.sdaDevOe),
		.resetInN(link.resetInN), .busWidthStrap(link.busWidthStrap),
		.busy(link.busy));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] nextRand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
			badCount++;
		end
	endtask

	task automatic wrapUp();
		if (badCount == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// Read bytes step by 8'h11 each time the device takes one
	always @(posedge clk)
		if (rdTaken === 1'b1)
			rdData <= rdData + 8'h11;

	always @(posedge clk)
	begin
		if (rxValid === 1'b1)
			check({rxIsData, rxByte},
				rxQ.size() != 0 ? rxQ.pop_front() : 9'hXXX);
		if (rdValid === 1'b1)
			check({1'b0, rdByte},
				rdQ.size() != 0 ? {1'b0, rdQ.pop_front()} : 9'hXXX);
	end

	task automatic xfer(input logic isData, input eps_byte_t b,
		input int nRd);
		int k;
		rxQ.push_back({isData, b});
		for (k = 0; k < nRd; k++)
			rdQ.push_back(rdData + 8'(8'h11 * k));
		k = 0;
		while (ready !== 1'b1 && k < 3000)
		begin
			tick(1);
			k++;
		end
		check(9'(ready), 9'h1);
		start = 1'b1;
		startIsData = isData;
		txByte = b;
		rdCount = 4'(nRd);
		tick(1);
		start = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 3000)
		begin
			tick(1);
			k++;
		end
		check(9'(done), 9'h1);
	endtask

	// Strap only moves while the device is held in reset
	task automatic setMode(input logic three);
		resetReq = 1'b1;
		waveformActive = 1'b1;
		tick(3);
		threeWire = three;
		tick(6);
		check(9'(busy), 9'h0);
		check(9'(link.busWidthStrap), 9'(three));
		resetReq = 1'b0;
		waveformActive = 1'b0;
		tick(8);
		check(9'(threeWireMode), 9'(three));
	endtask

	initial
	begin
		{rst_n, start, startIsData, threeWire, resetReq} = '0;
		{refreshDone, refreshIsFull, waveformActive, sensorActive} = '0;
		txByte = 8'h00;
		rdCount = 4'h0;
		tick(5);
		rst_n = 1'b1;
		tick(3);
		for (i = 1; i <= 6; i++)
		begin
			refreshIsFull = (i == 6);
			refreshDone = 1'b1;
			tick(1);
			refreshDone = 1'b0;
			tick(1);
			check(9'(fullRefreshDue), 9'(i == 5));
		end
		waveformActive = 1'b1;
		tick(8);
		check(9'(busy), 9'h1);
		check(9'(ready), 9'h0);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		waveformActive = 1'b0;
		sensorActive = 1'b1;
		tick(3);
		check(9'(link.busy), 9'h1);
		sensorActive = 1'b0;
		for (j = 0; j < 2; j++)
		begin
			setMode(j[0]);
			for (i = 0; i < 6; i++)
			begin
				seed = nextRand();
				xfer(seed[8], (seed[8] || seed[7:0] != RD_CMD) ?
					seed[7:0] : 8'h00, 0);
			end
			xfer(1'b1, RD_CMD, 0);
			xfer(1'b0, RD_CMD, 3);
			xfer(1'b0, RD_CMD, 1);
		end
		// Reset pin pulses mid-word: seven bits remain at select high and
		// must be dropped, or the next word comes out misaligned
		tick(1);
		startIsData = 1'b1;
		txByte = 8'h3C;
		rdCount = 4'h0;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(12);
		resetReq = 1'b1;
		tick(2);
		resetReq = 1'b0;
		tick(120);
		xfer(1'b1, 8'hA5, 0);
		tick(20);
		check(9'(rxQ.size() + rdQ.size()), 9'h0);
		wrapUp();
	end

	initial
	begin
		#(50 * 40000);
		badCount++;
		wrapUp();
	end
endmodule // tb

`default_nettype wire
